//--- design/cfcu_pkg.sv
// Shared constants and types for the control and condition unit
package cfcu_pkg;
   // ************************************************
   // Timing
   // ************************************************
   localparam int unsigned CLK_MHZ    = 200;
   localparam int unsigned OP_CYCLES  = 7;
   localparam logic [2:0]  OP_CNT_END = 3'(OP_CYCLES - 2);
   // ************************************************
   // Register offsets
   // ************************************************
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_DATA   = 8'h04;
   localparam logic [7:0] ADDR_FLAGS  = 8'h08;
   localparam logic [7:0] ADDR_CTRL   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_COND   = 8'h14;
   localparam logic [7:0] ADDR_AUX    = 8'h18;
   // ************************************************
   // Field positions
   // ************************************************
   localparam int FLG_C  = 7;
   localparam int FLG_Z  = 6;
   localparam int FLG_S  = 5;
   localparam int FLG_PV = 4;
   localparam int SEL_C  = 3;
   localparam int SEL_Z  = 2;
   localparam int SEL_S  = 1;
   localparam int SEL_PV = 0;
   localparam int SEL_VEC  = 1;
   localparam int SEL_NVEC = 0;
   localparam int CMD_OPND_LSB = 4;
   localparam int CMD_CSEL     = 8;
   localparam int CTL_SYS  = 14;
   localparam int CTL_VEC_EN  = 12;
   localparam int CTL_NVEC_EN = 11;
   localparam int ST_BUSY    = 0;
   localparam int ST_PRIV    = 1;
   localparam int ST_COND    = 2;
   localparam int ST_RES_IN  = 3;
   localparam int ST_RES_OUT = 4;
   localparam int ST_SYS     = 5;
   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic        SYS_RST   = 1'b1;
   localparam logic [15:0] AUX_RST   = 16'h0000;
   localparam logic [3:0]  CC_RST    = 4'h0;
   // ************************************************
   // Operations
   // ************************************************
   typedef enum logic [3:0] {
      OP_NOP, OP_FLAG_SET, OP_FLAG_CLR, OP_FLAG_COMP,
      OP_IRQ_MASK, OP_IRQ_UNMASK, OP_CTL_TO, OP_CTL_FROM,
      OP_FLGB_TO, OP_FLGB_FROM, OP_RES_TEST, OP_RES_REQ
   } cfcu_op_t;
   typedef enum logic {ST_IDLE, ST_EXEC} cfcu_state_t;
endpackage

//--- design/cfcu_sync.sv
// Three-stage input synchroniser that changes once two stages agree
`timescale 1ns/1ps
module cfcu_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Level in and out
   input  wire logic din,
   output logic      dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a change only when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout <= 1'b1;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end
endmodule // cfcu_sync

//--- design/cfcu_cond.sv
// Condition field evaluator against the four flags
`timescale 1ns/1ps
module cfcu_cond (
   // Condition field and flag byte
   input  wire logic [3:0] cc,
   input  wire logic [7:0] flags,
   // Result
   output logic            cond_true
);
   logic c;
   logic z;
   logic s;
   logic v;
   logic base;

   assign c = flags[cfcu_pkg::FLG_C];
   assign z = flags[cfcu_pkg::FLG_Z];
   assign s = flags[cfcu_pkg::FLG_S];
   assign v = flags[cfcu_pkg::FLG_PV];

   // Low three bits pick a test, bit 3 inverts it
   always_comb begin
      case (cc[2:0])
         3'h0: base = 1'b0; // RQ10
         3'h1: base = s ^ v; // RQ14
         3'h2: base = z | (s ^ v); // RQ15
         3'h3: base = c | z; // RQ16
         3'h4: base = v; // RQ12
         3'h5: base = s; // RQ11
         3'h6: base = z; // RQ11
         3'h7: base = c; // RQ13
         default: base = 1'b0;
      endcase
      cond_true = base ^ cc[3];
   end
endmodule // cfcu_cond

//--- design/cfcu_top.sv
// Control-instruction group, flag handling and condition evaluation
`timescale 1ns/1ps
// What this block does
// [RQ1] Set, clear, complement any mix of C, Z, S, P/V in 7 cycles
// [RQ2] Mask or unmask any mix of vectored and non-vectored interrupts in 7 cycles
// [RQ3] Interrupt, control-move and multi-micro operations run only in system mode
// [RQ4] Privileged operation in normal mode is dropped and raises an exception
// [RQ5] Copy general data to or from a control register in 7 cycles
// [RQ6] Copy a byte to or from the flag byte register in 7 cycles
// [RQ7] Resource test sets S when the line is low, clears it when high
// [RQ8] Resource line is sampled; active-low output makes resource requests
// [RQ9] Only the resource request operation drives a request
// [RQ10] Condition 0000 is never true, 1000 always true
// [RQ11] 0110/1110 test Z set/clear; 0101/1101 test S set/clear
// [RQ12] 0100/1100 test P/V set/clear
// [RQ13] 0111/1111 test C set/clear
// [RQ14] 1001 true when S xor P/V is 0, 0001 when it is 1
// [RQ15] 0010 true when Z or (S xor P/V) is 1, 1010 when 0
// [RQ16] 1011 true when C and Z both 0, 0011 when C or Z is 1
module cfcu_top (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Multi-micro lines
   input  wire logic        resource_line_input_n,
   output logic             resource_line_output_n,
   // Mode, interrupt enables, exception and condition
   output logic             system_mode,
   output logic             vectored_irq_en,
   output logic             nonvectored_irq_en,
   output logic             priv_exc,
   output logic             cond_true
);
   // ************************************************
   // Declarations
   // ************************************************
   cfcu_pkg::cfcu_state_t state_q;
   cfcu_pkg::cfcu_op_t    op_q;
   cfcu_pkg::cfcu_op_t    cmd_op;
   logic [2:0]  cnt_q;
   logic [3:0]  opnd_q;
   logic        csel_q;
   logic [7:0]  flags_q;
   logic [15:0] aux_q;
   logic [15:0] data_q;
   logic [3:0]  cc_q;
   logic        priv_st_q;
   logic        res_in_s;
   logic        cond_w;
   logic        setup;
   logic        access;
   logic        bad_addr;
   logic        wr_cmd;
   logic        start_try;
   logic        priv_op;
   logic        start_go;
   logic        priv_hit;
   logic        finish;
   logic [7:0]  fmask;
   logic [15:0] ctl_word;

   // ************************************************
   // Helpers
   // ************************************************
   cfcu_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (resource_line_input_n),
      .dout    (res_in_s)
   );

   cfcu_cond u_cond (
      .cc        (cc_q),
      .flags     (flags_q),
      .cond_true (cond_w)
   );

   // ************************************************
   // APB decode
   // ************************************************
   assign setup  = psel && !penable;
   assign access = psel && penable && pready && !pslverr;
   assign bad_addr = !(paddr inside {cfcu_pkg::ADDR_CMD, cfcu_pkg::ADDR_DATA,
      cfcu_pkg::ADDR_FLAGS, cfcu_pkg::ADDR_CTRL, cfcu_pkg::ADDR_STATUS,
      cfcu_pkg::ADDR_COND, cfcu_pkg::ADDR_AUX});
   assign wr_cmd = access && pwrite && (paddr == cfcu_pkg::ADDR_CMD);
   assign cmd_op = cfcu_pkg::cfcu_op_t'(pwdata[3:0]);
   assign ctl_word = {1'b0, system_mode, 1'b0, vectored_irq_en,
                      nonvectored_irq_en, 3'h0, flags_q};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Unmapped address, or a command or data write while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && (bad_addr || (pwrite && state_q == cfcu_pkg::ST_EXEC &&
                    (paddr == cfcu_pkg::ADDR_CMD || paddr == cfcu_pkg::ADDR_DATA)));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr)
            cfcu_pkg::ADDR_CMD:    prdata <= {23'h0, csel_q, opnd_q, op_q};
            cfcu_pkg::ADDR_DATA:   prdata <= {16'h0, data_q};
            cfcu_pkg::ADDR_FLAGS:  prdata <= {24'h0, flags_q};
            cfcu_pkg::ADDR_CTRL:   prdata <= {16'h0, ctl_word};
            cfcu_pkg::ADDR_STATUS: prdata <= {26'h0, system_mode, !resource_line_output_n,
                                              !res_in_s, cond_true, priv_st_q,
                                              state_q == cfcu_pkg::ST_EXEC};
            cfcu_pkg::ADDR_COND:   prdata <= {27'h0, cc_q, cond_true};
            cfcu_pkg::ADDR_AUX:    prdata <= {16'h0, aux_q};
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************
   // Operation sequencer
   // ************************************************
   assign start_try = wr_cmd && cmd_op != cfcu_pkg::OP_NOP;
   assign priv_op = cmd_op inside {cfcu_pkg::OP_IRQ_MASK, cfcu_pkg::OP_IRQ_UNMASK,
      cfcu_pkg::OP_CTL_TO, cfcu_pkg::OP_CTL_FROM, cfcu_pkg::OP_RES_TEST,
      cfcu_pkg::OP_RES_REQ}; // RQ3
   assign priv_hit = start_try && priv_op && !system_mode; // RQ4
   assign start_go = start_try && !priv_hit;
   assign finish = state_q == cfcu_pkg::ST_EXEC && cnt_q == cfcu_pkg::OP_CNT_END;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= cfcu_pkg::ST_IDLE;
         cnt_q   <= 3'h0;
      end else begin
         case (state_q)
            cfcu_pkg::ST_IDLE: begin
               cnt_q <= 3'h0;
               if (start_go) begin
                  state_q <= cfcu_pkg::ST_EXEC;
               end
            end
            cfcu_pkg::ST_EXEC: begin
               cnt_q <= cnt_q + 3'h1;
               if (finish) begin
                  state_q <= cfcu_pkg::ST_IDLE;
               end
            end
            default: state_q <= cfcu_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q   <= cfcu_pkg::OP_NOP;
         opnd_q <= 4'h0;
         csel_q <= 1'b0;
      end else if (start_go) begin
         op_q   <= cmd_op;
         opnd_q <= pwdata[cfcu_pkg::CMD_OPND_LSB +: 4];
         csel_q <= pwdata[cfcu_pkg::CMD_CSEL];
      end
   end

   // Exception pulse and sticky status; write 1 clears, a new hit wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priv_exc  <= 1'b0;
         priv_st_q <= 1'b0;
      end else begin
         priv_exc <= priv_hit; // RQ4
         if (priv_hit) begin
            priv_st_q <= 1'b1;
         end else if (access && pwrite && paddr == cfcu_pkg::ADDR_STATUS &&
                      pwdata[cfcu_pkg::ST_PRIV]) begin
            priv_st_q <= 1'b0;
         end
      end
   end

   // ************************************************
   // Flags
   // ************************************************
   assign fmask = {opnd_q[cfcu_pkg::SEL_C], opnd_q[cfcu_pkg::SEL_Z],
                   opnd_q[cfcu_pkg::SEL_S], opnd_q[cfcu_pkg::SEL_PV], 4'h0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= cfcu_pkg::FLAGS_RST;
      end else if (finish) begin
         case (op_q)
            cfcu_pkg::OP_FLAG_SET:  flags_q <= flags_q | fmask; // RQ1
            cfcu_pkg::OP_FLAG_CLR:  flags_q <= flags_q & ~fmask; // RQ1
            cfcu_pkg::OP_FLAG_COMP: flags_q <= flags_q ^ fmask; // RQ1
            cfcu_pkg::OP_FLGB_TO:   flags_q <= data_q[7:0]; // RQ6
            cfcu_pkg::OP_CTL_TO: begin
               if (!csel_q) begin
                  flags_q <= data_q[7:0]; // RQ5
               end
            end
            cfcu_pkg::OP_RES_TEST,
            cfcu_pkg::OP_RES_REQ:   flags_q[cfcu_pkg::FLG_S] <= !res_in_s; // RQ7
            default:                flags_q <= flags_q;
         endcase
      end
   end

   // ************************************************
   // Control word and auxiliary control register
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_mode        <= cfcu_pkg::SYS_RST;
         vectored_irq_en    <= 1'b0;
         nonvectored_irq_en <= 1'b0;
      end else if (finish) begin
         case (op_q)
            cfcu_pkg::OP_IRQ_MASK: begin
               if (opnd_q[cfcu_pkg::SEL_VEC]) vectored_irq_en <= 1'b0; // RQ2
               if (opnd_q[cfcu_pkg::SEL_NVEC]) nonvectored_irq_en <= 1'b0; // RQ2
            end
            cfcu_pkg::OP_IRQ_UNMASK: begin
               if (opnd_q[cfcu_pkg::SEL_VEC]) vectored_irq_en <= 1'b1; // RQ2
               if (opnd_q[cfcu_pkg::SEL_NVEC]) nonvectored_irq_en <= 1'b1; // RQ2
            end
            cfcu_pkg::OP_CTL_TO: begin
               if (!csel_q) begin
                  system_mode        <= data_q[cfcu_pkg::CTL_SYS]; // RQ5
                  vectored_irq_en    <= data_q[cfcu_pkg::CTL_VEC_EN];
                  nonvectored_irq_en <= data_q[cfcu_pkg::CTL_NVEC_EN];
               end
            end
            default: system_mode <= system_mode;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_q <= cfcu_pkg::AUX_RST;
      end else if (finish && op_q == cfcu_pkg::OP_CTL_TO && csel_q) begin
         aux_q <= data_q; // RQ5
      end
   end

   // General register image: written by software, loaded by moves out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= 16'h0000;
      end else if (finish && op_q == cfcu_pkg::OP_CTL_FROM) begin
         data_q <= csel_q ? aux_q : ctl_word; // RQ5
      end else if (finish && op_q == cfcu_pkg::OP_FLGB_FROM) begin
         data_q <= {8'h00, flags_q}; // RQ6
      end else if (access && pwrite && paddr == cfcu_pkg::ADDR_DATA) begin
         data_q <= pwdata[15:0];
      end
   end

   // ************************************************
   // Resource request and condition
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resource_line_output_n <= 1'b1;
      end else if (start_go && cmd_op == cfcu_pkg::OP_RES_REQ) begin
         resource_line_output_n <= 1'b0; // RQ9
      end else if (finish) begin
         resource_line_output_n <= 1'b1; // RQ8
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_q      <= cfcu_pkg::CC_RST;
         cond_true <= 1'b0;
      end else begin
         cond_true <= cond_w; // RQ10
         if (access && pwrite && paddr == cfcu_pkg::ADDR_COND) begin
            cc_q <= pwdata[4:1];
         end
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag_set_time: assert property ( // RQ1
      start_go && cmd_op == cfcu_pkg::OP_FLAG_SET |-> ##7
      flags_q == ($past(flags_q, 7) | $past(
      {pwdata[7], pwdata[6], pwdata[5], pwdata[4], 4'h0}, 7)))
      else $error("flag set wrong or late");
   a_flag_comp_hold: assert property ( // RQ1
      start_go && cmd_op == cfcu_pkg::OP_FLAG_COMP |=> $stable(flags_q) [*6])
      else $error("flags changed early");
   a_irq_unmask: assert property ( // RQ2
      start_go && cmd_op == cfcu_pkg::OP_IRQ_UNMASK && pwdata[5] |-> ##7 vectored_irq_en)
      else $error("vectored irq not unmasked in 7 cycles");
   a_priv_block: assert property ( // RQ3
      priv_hit |=> priv_exc && state_q == cfcu_pkg::ST_IDLE ##1 !priv_exc)
      else $error("privileged op ran in normal mode");
   a_priv_only: assert property ( // RQ4
      priv_exc |-> $past(start_try && !system_mode))
      else $error("spurious privilege exception");
   a_ctl_read: assert property ( // RQ5
      start_go && cmd_op == cfcu_pkg::OP_CTL_FROM && !pwdata[8] |-> ##7
      data_q == $past(ctl_word, 7))
      else $error("control word move wrong");
   a_flgb_load: assert property ( // RQ6
      start_go && cmd_op == cfcu_pkg::OP_FLGB_TO |-> ##7 flags_q == $past(data_q[7:0], 7))
      else $error("flag byte load wrong");
   a_res_test: assert property ( // RQ7
      finish && op_q == cfcu_pkg::OP_RES_TEST |=> flags_q[cfcu_pkg::FLG_S] == !$past(res_in_s))
      else $error("resource test gave wrong sign");
   a_res_pulse: assert property ( // RQ8
      start_go && cmd_op == cfcu_pkg::OP_RES_REQ |=> !resource_line_output_n [*6]
      ##1 resource_line_output_n)
      else $error("resource request width wrong");
   a_res_only_req: assert property ( // RQ9
      !resource_line_output_n |-> state_q == cfcu_pkg::ST_EXEC && op_q == cfcu_pkg::OP_RES_REQ)
      else $error("request outside request op");
   a_cond_fixed: assert property ( // RQ10
      $past(cc_q[2:0] == 3'h0) |-> cond_true == $past(cc_q[3]))
      else $error("fixed condition wrong");
   a_cond_zero: assert property ( // RQ11
      $past(cc_q == 4'h6) |-> cond_true == $past(flags_q[cfcu_pkg::FLG_Z]))
      else $error("zero condition wrong");
   a_cond_pv: assert property ( // RQ12
      $past(cc_q == 4'hC) |-> cond_true == !$past(flags_q[cfcu_pkg::FLG_PV]))
      else $error("overflow condition wrong");
   a_cond_carry: assert property ( // RQ13
      $past(cc_q == 4'hF) |-> cond_true == !$past(flags_q[cfcu_pkg::FLG_C]))
      else $error("carry condition wrong");
   a_cond_ge: assert property ( // RQ14
      $past(cc_q == 4'h9) |-> cond_true ==
      !$past(flags_q[cfcu_pkg::FLG_S] ^ flags_q[cfcu_pkg::FLG_PV]))
      else $error("signed ge wrong");
   a_cond_le: assert property ( // RQ15
      $past(cc_q == 4'h2) |-> cond_true == $past(flags_q[cfcu_pkg::FLG_Z] |
      (flags_q[cfcu_pkg::FLG_S] ^ flags_q[cfcu_pkg::FLG_PV])))
      else $error("signed le wrong");
   a_cond_ugt: assert property ( // RQ16
      $past(cc_q == 4'hB) |-> cond_true ==
      !$past(flags_q[cfcu_pkg::FLG_C] | flags_q[cfcu_pkg::FLG_Z]))
      else $error("unsigned gt wrong");

   c_flag_op: cover property (finish && op_q == cfcu_pkg::OP_FLAG_COMP);
   c_priv_hit: cover property (priv_hit);
   c_res_req: cover property (finish && op_q == cfcu_pkg::OP_RES_REQ);
   c_cond_true: cover property (cond_true && cc_q == 4'h2);
endmodule // cfcu_top

//--- testbench/cfcu_resource_model.sv
// Model of the shared multi-micro resource lines seen by the block
`timescale 1ns/1ps
module cfcu_resource_model (
   // Request from another master and from the block
   input  wire logic other_req,
   input  wire logic resource_line_output_n,
   // Sensed shared line
   output logic      resource_line_input_n
);
   // Pulled-up shared line, low while any master requests
   assign resource_line_input_n = ~other_req & resource_line_output_n;
endmodule // cfcu_resource_model

//--- testbench/tb_cpu_control_flag_condition_unit.sv
// Self-checking bench for the control, flag and condition unit
`timescale 1ns/1ps
module tb_cpu_control_flag_condition_unit;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        other_req, res_in_n, res_out_n, system_mode, vec_en, nvec_en, priv_exc, cond_true;
   int          fails, n_compared, req_cycles;

   cfcu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .resource_line_input_n(res_in_n), .resource_line_output_n(res_out_n), .system_mode(system_mode),
      .vectored_irq_en(vec_en), .nonvectored_irq_en(nvec_en), .priv_exc(priv_exc), .cond_true(cond_true));
   cfcu_resource_model u_res (.other_req(other_req), .resource_line_output_n(res_out_n),
      .resource_line_input_n(res_in_n));

   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   // Cycles in which the block drives a resource request
   always @(posedge pclk) begin
      if (presetn === 1'h1 && res_out_n === 1'h0) req_cycles++;
   end
   // ************************************************
   // Bus and check helpers
   // ************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (n == 16) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic op(input logic [3:0] code, input logic [3:0] opnd, input logic csel);
      apb(1'h1, cfcu_pkg::ADDR_CMD, {23'h0, csel, opnd, code});
      repeat (7) @(posedge pclk);
   endtask
   function automatic logic cond_exp(input logic [3:0] cc, input logic [3:0] f);
      logic c, z, s, v;
      {c, z, s, v} = f;
      case (cc)
         4'h0: return 1'h0;
         4'h8: return 1'h1;
         4'h6: return z;
         4'hE: return !z;
         4'h5: return s;
         4'hD: return !s;
         4'h4: return v;
         4'hC: return !v;
         4'h7: return c;
         4'hF: return !c;
         4'h9: return !(s ^ v);
         4'h1: return s ^ v;
         4'h2: return z | (s ^ v);
         4'hA: return !(z | (s ^ v));
         4'hB: return !c & !z;
         default: return c | z;
      endcase
   endfunction
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset;
      chk(system_mode, 1'h1);
      chk(res_out_n, 1'h1);
      apb(1'h0, cfcu_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h4000);
      apb(1'h0, 8'h1C, 32'h0);
      chk(err, 1'h1);
   endtask
   task automatic flags_is(input logic [7:0] exp);
      apb(1'h0, cfcu_pkg::ADDR_FLAGS, 32'h0);
      chk(rd[7:0], exp);
   endtask
   task automatic t_flags;
      apb(1'h1, cfcu_pkg::ADDR_DATA, 32'h50);
      op(cfcu_pkg::OP_FLGB_TO, 4'h0, 1'h0);
      flags_is(8'h50);
      op(cfcu_pkg::OP_FLAG_SET, 4'h8, 1'h0);
      flags_is(8'hD0);
      op(cfcu_pkg::OP_FLAG_CLR, 4'h5, 1'h0);
      flags_is(8'h80);
      op(cfcu_pkg::OP_FLAG_COMP, 4'hF, 1'h0);
      flags_is(8'h70);
      apb(1'h1, cfcu_pkg::ADDR_CMD, {24'h0, 4'h8, cfcu_pkg::OP_FLAG_COMP});
      apb(1'h1, cfcu_pkg::ADDR_CMD, {24'h0, 4'h8, cfcu_pkg::OP_FLAG_COMP});
      chk(err, 1'h1);
      repeat (7) @(posedge pclk);
      flags_is(8'hF0);
      op(cfcu_pkg::OP_FLGB_FROM, 4'h0, 1'h0);
      apb(1'h0, cfcu_pkg::ADDR_DATA, 32'h0);
      chk(rd[7:0], 8'hF0);
   endtask
   task automatic t_irq;
      apb(1'h1, cfcu_pkg::ADDR_CMD, {24'h0, 4'h2, cfcu_pkg::OP_IRQ_UNMASK});
      repeat (5) @(posedge pclk);
      #1 chk(vec_en, 1'h0);
      @(posedge pclk);
      #1 chk(vec_en, 1'h1);
      chk(nvec_en, 1'h0);
      op(cfcu_pkg::OP_IRQ_UNMASK, 4'h1, 1'h0);
      chk(nvec_en, 1'h1);
      op(cfcu_pkg::OP_IRQ_MASK, 4'h3, 1'h0);
      chk({vec_en, nvec_en}, 2'h0);
      op(cfcu_pkg::OP_IRQ_UNMASK, 4'h3, 1'h0);
      apb(1'h0, cfcu_pkg::ADDR_CTRL, 32'h0);
      chk(rd[12:11], 2'h3);
   endtask
   task automatic t_ctl;
      apb(1'h1, cfcu_pkg::ADDR_DATA, 32'h1234);
      op(cfcu_pkg::OP_CTL_TO, 4'h0, 1'h1);
      apb(1'h0, cfcu_pkg::ADDR_AUX, 32'h0);
      chk(rd[15:0], 16'h1234);
      apb(1'h1, cfcu_pkg::ADDR_DATA, 32'h0);
      op(cfcu_pkg::OP_CTL_FROM, 4'h0, 1'h1);
      apb(1'h0, cfcu_pkg::ADDR_DATA, 32'h0);
      chk(rd[15:0], 16'h1234);
      op(cfcu_pkg::OP_CTL_FROM, 4'h0, 1'h0);
      apb(1'h0, cfcu_pkg::ADDR_DATA, 32'h0);
      chk(rd[15:0], 16'h58F0);
   endtask
   task automatic t_cond;
      for (int f = 0; f < 16; f++) begin
         apb(1'h1, cfcu_pkg::ADDR_DATA, {24'h0, 4'(f), 4'h0});
         op(cfcu_pkg::OP_FLGB_TO, 4'h0, 1'h0);
         for (int c = 0; c < 16; c++) begin
            apb(1'h1, cfcu_pkg::ADDR_COND, {27'h0, 4'(c), 1'h0});
            apb(1'h0, cfcu_pkg::ADDR_COND, 32'h0);
            chk(rd[0], cond_exp(4'(c), 4'(f)));
            chk(cond_true, cond_exp(4'(c), 4'(f)));
         end
      end
   endtask
   task automatic t_resource;
      @(posedge pclk);
      other_req <= 1'h1;
      repeat (6) @(posedge pclk);
      op(cfcu_pkg::OP_RES_TEST, 4'h0, 1'h0);
      apb(1'h0, cfcu_pkg::ADDR_STATUS, 32'h0);
      chk(rd[3], 1'h1);
      apb(1'h0, cfcu_pkg::ADDR_FLAGS, 32'h0);
      chk(rd[5], 1'h1);
      other_req <= 1'h0;
      repeat (6) @(posedge pclk);
      op(cfcu_pkg::OP_RES_TEST, 4'h0, 1'h0);
      apb(1'h0, cfcu_pkg::ADDR_FLAGS, 32'h0);
      chk(rd[5], 1'h0);
      chk(req_cycles, 0);
      op(cfcu_pkg::OP_RES_REQ, 4'h0, 1'h0);
      chk(req_cycles, 6);
   endtask
   task automatic t_priv;
      cfcu_pkg::cfcu_op_t pops[6] = '{cfcu_pkg::OP_IRQ_MASK, cfcu_pkg::OP_IRQ_UNMASK, cfcu_pkg::OP_CTL_TO,
                                      cfcu_pkg::OP_CTL_FROM, cfcu_pkg::OP_RES_TEST, cfcu_pkg::OP_RES_REQ};
      int n;
      apb(1'h1, cfcu_pkg::ADDR_DATA, 32'h0);
      op(cfcu_pkg::OP_CTL_TO, 4'h0, 1'h0);
      chk(system_mode, 1'h0);
      foreach (pops[i]) begin
         apb(1'h1, cfcu_pkg::ADDR_CMD, {24'h0, 4'h3, pops[i]});
         n = 0;
         repeat (3) begin
            #1 n += int'(priv_exc === 1'h1);
            @(posedge pclk);
         end
         chk(n, 1);
         repeat (6) @(posedge pclk);
      end
      chk({vec_en, nvec_en}, 2'h0);
      chk(req_cycles, 6);
      apb(1'h0, cfcu_pkg::ADDR_STATUS, 32'h0);
      chk(rd[1], 1'h1);
      apb(1'h1, cfcu_pkg::ADDR_STATUS, 32'h2);
      apb(1'h0, cfcu_pkg::ADDR_STATUS, 32'h0);
      chk(rd[1], 1'h0);
      op(cfcu_pkg::OP_FLAG_CLR, 4'hF, 1'h0);
      op(cfcu_pkg::OP_FLAG_SET, 4'h4, 1'h0);
      flags_is(8'h40);
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
      paddr = 8'h0; pwdata = 32'h0; other_req = 1'h0;
      fails = 0; n_compared = 0; req_cycles = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_flags();
      t_irq();
      t_ctl();
      t_cond();
      t_resource();
      t_priv();
      end_of_test();
   end
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
endmodule // tb_cpu_control_flag_condition_unit
